// ===== rtl/ccrb_pkg.sv
`default_nettype none
package ccrb_pkg;
   localparam logic [6:0] IDX_OFFSET_VALUE = 7'h73;
   localparam logic [6:0] IDX_THERMAL_AND_CLEAR = 7'h74;
   localparam logic [6:0] IDX_TRIM_CONTROL = 7'h75;
   localparam logic [6:0] IDX_FILL_DURATION_LOW = 7'h76;
   localparam logic [6:0] IDX_FILL_DURATION_HIGH = 7'h77;
   localparam logic [6:0] IDX_DRAIN_DURATION_LOW = 7'h78;
   localparam logic [6:0] IDX_DRAIN_DURATION_HIGH = 7'h79;
   localparam logic [6:0] IDX_IDLE_LOSS_TALLY_LOW = 7'h7a;
   localparam logic [6:0] IDX_IDLE_LOSS_TALLY_HIGH = 7'h7b;
   localparam logic [6:0] IDX_FILL_TALLY_LOW = 7'h7c;
   localparam logic [6:0] IDX_FILL_TALLY_HIGH = 7'h7d;
   localparam logic [6:0] IDX_DRAIN_TALLY_LOW = 7'h7e;
   localparam logic [6:0] IDX_DRAIN_TALLY_HIGH = 7'h7f;
   // Command byte fields.
   localparam int CMD_DIR_BIT = 7;
   // Trim control fields.
   localparam int TRIM_OVERRIDE_BIT = 7;
   localparam int TRIM_CAL_BIT = 6;
   localparam int TRIM_FILL_SLOW_BIT = 5;
   localparam int TRIM_DRAIN_SLOW_BIT = 4;
   localparam int TRIM_CODE_MSB = 3;
   localparam int TRIM_CODE_LSB = 1;
   localparam logic [2:0] QUIET_CODE_RESET = 3'h7;
   // Thermal-and-clear fields.
   localparam int THERM_MSB = 7;
   localparam int THERM_LSB = 5;
   localparam int CLR_FILL_DURATION_BIT = 4;
   localparam int CLR_DRAIN_DURATION_BIT = 3;
   localparam int CLR_IDLE_LOSS_BIT = 2;
   localparam int CLR_FILL_TALLY_BIT = 1;
   localparam int CLR_DRAIN_TALLY_BIT = 0;
   // Temperature steps: 0 is below 0 C, 3 is 20 to 30 C, 7 is above 60 C.
   localparam logic [2:0] THERM_STEP_NOMINAL = 3'h3;
   localparam int THERM_STEP_MAX = 7;
   // Timebase.
   localparam int CLK_HZ = 40000000;
   localparam int SECONDS_PER_HOUR = 3600;
   localparam longint CYCLES_PER_HOUR = 64'(CLK_HZ) * SECONDS_PER_HOUR;
   localparam int FAST_RATE_PER_HOUR = 4096;
   localparam int SLOW_RATE_PER_HOUR = 16;
   localparam int IDLE_MAX_RATE_PER_HOUR = 16;
   localparam logic [7:0] OFFSET_RESET = 8'h00;
   localparam logic [15:0] TALLY_RESET = 16'h0000;
endpackage : ccrb_pkg
`default_nettype wire

// ===== rtl/ccrb_register_bank.sv
// Operation
// - Command bits 6..0 pick the register index to access.
// - Command bit 7: 0 returns the register, 1 stores the next byte.
// - Discharge event increments drain tally 7F:7E, wrapping past FFFF.
// - Charge event increments fill tally 7D:7C, wrapping past FFFF.
// - Idle loss rate 1/h nominal, doubling per step to 16/h, halving to 1/8h.
// - Idle loss tally 7B:7A counts only in normal operating mode.
// - Drain duration 79:78 counts 4096 per hour while discharging.
// - Drain duration rollover sets drain-slow flag; then 16 per hour.
// - Second rollover clears slow flag; host clears timers within 170 days.
// - Fill duration 77:76 counts 4096 per hour while charging.
// - Fill duration rollover sets fill-slow flag; then 16 per hour.
// - Fill-slow flag at trim bit 5, drain-slow at trim bit 4.
// - Override bit 7 lets calibration start regardless of line level.
// - Override bit returns to 0 after a valid calibration.
// - Calibration bit 6 enables calibration; cleared when offset latched.
// - Calibration needs one continuous hour of quiet conditions.
// - Line rise or loud sense restarts calibration timing; request stays.
// - Trim bits 3..1 hold quiet threshold code; code 0 invalid.
// - Reset loads threshold code with all ones.
// - Thermal-and-clear bits 7..5 show the present temperature step.
// - Writing 1 to clear bits zeroes counter; bit then returns to 0.
// - Bit4 fill duration+flag, 3 drain duration+flag, 2 idle, 1 fill, 0 drain.
// - Offset register 73 holds two's complement offset, host read/write.
`default_nettype none
module ccrb_register_bank
#(
   parameter longint HOUR_CYCLES = ccrb_pkg::CYCLES_PER_HOUR
)
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic cmd_valid,
   input wire logic [7:0] host_command_byte,
   input wire logic [7:0] wr_data,
   input wire logic single_wire_line,
   input wire logic normal_mode,
   input wire logic drain_event,
   input wire logic fill_event,
   input wire logic draining,
   input wire logic filling,
   input wire logic sense_quiet,
   input wire logic [2:0] thermal_step,
   input wire logic [7:0] measured_offset,
   output logic [7:0] rd_data,
   output logic rd_valid,
   output logic cal_busy,
   output logic [2:0] quiet_threshold_code
);
   import ccrb_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   localparam longint FAST_DIV = HOUR_CYCLES / FAST_RATE_PER_HOUR;
   localparam longint SLOW_DIV = HOUR_CYCLES / SLOW_RATE_PER_HOUR;
   localparam longint IDLE_DIV = HOUR_CYCLES / IDLE_MAX_RATE_PER_HOUR;
   // Forty bits hold a full hour of cycles at the default clock.
   localparam int CW = 40;

   // The line is a pin, so it passes two flops before anything reads it.
   // It resets to the idle high level, so that leaving reset never looks
   // like a low line and never starts calibration timing early.
   logic line_s1_reg;
   logic line_s2_reg;
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         line_s1_reg <= 1'b1;
         line_s2_reg <= 1'b1;
      end
      else
      begin
         line_s1_reg <= single_wire_line;
         line_s2_reg <= line_s1_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Command decode.
   // The serial front end hands over a whole command byte together with
   // its data byte; bit timing on the line is not handled here.
   logic [6:0] cmd_index;
   logic cmd_write;
   logic cmd_read;
   assign cmd_index = host_command_byte[6:0];
   assign cmd_write = cmd_valid && host_command_byte[CMD_DIR_BIT];
   assign cmd_read = cmd_valid && !host_command_byte[CMD_DIR_BIT];

   function automatic logic hit(input logic [6:0] idx,
                                input logic [6:0] target);
      hit = (idx == target);
   endfunction

   logic wr_trim;
   logic wr_therm;
   logic wr_offset;
   assign wr_trim = cmd_write && hit(cmd_index, IDX_TRIM_CONTROL);
   assign wr_therm = cmd_write && hit(cmd_index, IDX_THERMAL_AND_CLEAR);
   assign wr_offset = cmd_write && hit(cmd_index, IDX_OFFSET_VALUE);

   ////////////////////////////////////////////////////////////////////////
   // Timebase ticks.
   // Both dividers run free from reset, so a timer that starts mid-period
   // may see its first tick early; the error stays below one tick.
   logic [CW-1:0] fast_cnt_reg;
   logic [CW-1:0] slow_cnt_reg;
   logic fast_tick;
   logic slow_tick;
   assign fast_tick = (fast_cnt_reg == CW'(FAST_DIV - 1));
   assign slow_tick = (slow_cnt_reg == CW'(SLOW_DIV - 1));
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         fast_cnt_reg <= '0;
         slow_cnt_reg <= '0;
      end
      else
      begin
         fast_cnt_reg <= fast_tick ? '0 : fast_cnt_reg + 1'b1;
         slow_cnt_reg <= slow_tick ? '0 : slow_cnt_reg + 1'b1;
      end
   end

   // Idle loss: base tick at 16 per hour, then a temperature dependent
   // prescale of 1 (step 7) up to 128 (step 0).
   // A step change takes effect at the next base tick.
   logic [CW-1:0] idle_cnt_reg;
   logic [6:0] idle_pre_reg;
   logic idle_base;
   logic [6:0] idle_pre_top;
   logic idle_tick;
   assign idle_base = (idle_cnt_reg == CW'(IDLE_DIV - 1));
   assign idle_pre_top = 7'((8'h01 << (3'(THERM_STEP_MAX) - thermal_step))
                            - 8'h01);
   assign idle_tick = idle_base && (idle_pre_reg >= idle_pre_top);
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         idle_cnt_reg <= '0;
         idle_pre_reg <= '0;
      end
      else
      begin
         idle_cnt_reg <= idle_base ? '0 : idle_cnt_reg + 1'b1;
         if (idle_tick)
            idle_pre_reg <= '0;
         else if (idle_base)
            idle_pre_reg <= idle_pre_reg + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Clear strobes from the thermal-and-clear write.
   // A clear lasts only the cycle of the write and beats a count in that
   // same cycle, so the bit can read back 0 at once.
   logic [4:0] clr;
   assign clr = wr_therm ? wr_data[4:0] : 5'h00;

   // Counters.
   // Tallies wrap past the top; keeping them in range is left to the
   // host, which clears them through the thermal-and-clear register.
   logic [15:0] drain_tally_reg;
   logic [15:0] fill_tally_reg;
   logic [15:0] idle_tally_reg;
   logic [15:0] drain_dur_reg;
   logic [15:0] fill_dur_reg;
   logic drain_slow_reg;
   logic fill_slow_reg;

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         drain_tally_reg <= TALLY_RESET;
      else if (clr[CLR_DRAIN_TALLY_BIT])
         drain_tally_reg <= TALLY_RESET;
      else if (drain_event)
         drain_tally_reg <= drain_tally_reg + 16'h0001;
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         fill_tally_reg <= TALLY_RESET;
      else if (clr[CLR_FILL_TALLY_BIT])
         fill_tally_reg <= TALLY_RESET;
      else if (fill_event)
         fill_tally_reg <= fill_tally_reg + 16'h0001;
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         idle_tally_reg <= TALLY_RESET;
      else if (clr[CLR_IDLE_LOSS_BIT])
         idle_tally_reg <= TALLY_RESET;
      else if (normal_mode && idle_tick)
         idle_tally_reg <= idle_tally_reg + 16'h0001;
   end

   // Duration timers: fast tick until the first rollover, slow after.
   // The slow flag toggles on each rollover, so a second rollover clears
   // it and the rate returns to fast; the host must clear timers in time.
   logic drain_step;
   logic fill_step;
   assign drain_step = draining && (drain_slow_reg ? slow_tick : fast_tick);
   assign fill_step = filling && (fill_slow_reg ? slow_tick : fast_tick);

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         drain_dur_reg <= TALLY_RESET;
         drain_slow_reg <= 1'b0;
      end
      else if (clr[CLR_DRAIN_DURATION_BIT])
      begin
         drain_dur_reg <= TALLY_RESET;
         drain_slow_reg <= 1'b0;
      end
      else if (drain_step)
      begin
         drain_dur_reg <= drain_dur_reg + 16'h0001;
         if (drain_dur_reg == 16'hffff)
            drain_slow_reg <= !drain_slow_reg;
      end
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         fill_dur_reg <= TALLY_RESET;
         fill_slow_reg <= 1'b0;
      end
      else if (clr[CLR_FILL_DURATION_BIT])
      begin
         fill_dur_reg <= TALLY_RESET;
         fill_slow_reg <= 1'b0;
      end
      else if (fill_step)
      begin
         fill_dur_reg <= fill_dur_reg + 16'h0001;
         if (fill_dur_reg == 16'hffff)
            fill_slow_reg <= !fill_slow_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Calibration: one continuous hour of quiet conditions.
   // The hour counter restarts whenever a condition drops, so only an
   // unbroken hour completes and latches the offset.
   logic override_reg;
   logic cal_req_reg;
   logic [2:0] code_reg;
   logic [7:0] offset_reg;
   logic [CW-1:0] cal_cnt_reg;
   logic cal_ok;
   logic cal_done;
   assign cal_ok = cal_req_reg && sense_quiet
                   && (override_reg || !line_s2_reg);
   assign cal_done = cal_ok && (cal_cnt_reg == CW'(HOUR_CYCLES - 1));

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         cal_cnt_reg <= '0;
      else if (!cal_ok || cal_done)
         cal_cnt_reg <= '0;
      else
         cal_cnt_reg <= cal_cnt_reg + 1'b1;
   end

   // A host write in the completion cycle loses to the hardware clear, so
   // a stale request cannot survive a freshly latched offset.
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         override_reg <= 1'b0;
         cal_req_reg <= 1'b0;
         code_reg <= QUIET_CODE_RESET;
      end
      else
      begin
         if (wr_trim)
         begin
            override_reg <= wr_data[TRIM_OVERRIDE_BIT];
            cal_req_reg <= wr_data[TRIM_CAL_BIT];
            code_reg <= wr_data[TRIM_CODE_MSB:TRIM_CODE_LSB];
         end
         if (cal_done)
         begin
            override_reg <= 1'b0;
            cal_req_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         offset_reg <= OFFSET_RESET;
      else if (cal_done)
         offset_reg <= measured_offset;
      else if (wr_offset)
         offset_reg <= wr_data;
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path. Clear bits always read 0: clearing completes in one cycle.
   // The two bytes of a counter are read by separate commands with no
   // snapshot, so a count between them can tear the pair; a host that
   // needs a clean value reads it twice.
   logic [7:0] rd_mux;
   always_comb
   begin
      case (cmd_index)
         IDX_OFFSET_VALUE: rd_mux = offset_reg;
         IDX_THERMAL_AND_CLEAR: rd_mux = {thermal_step, 5'h00};
         IDX_TRIM_CONTROL: rd_mux = {override_reg, cal_req_reg,
                                     fill_slow_reg, drain_slow_reg,
                                     code_reg, 1'b0};
         IDX_FILL_DURATION_LOW: rd_mux = fill_dur_reg[7:0];
         IDX_FILL_DURATION_HIGH: rd_mux = fill_dur_reg[15:8];
         IDX_DRAIN_DURATION_LOW: rd_mux = drain_dur_reg[7:0];
         IDX_DRAIN_DURATION_HIGH: rd_mux = drain_dur_reg[15:8];
         IDX_IDLE_LOSS_TALLY_LOW: rd_mux = idle_tally_reg[7:0];
         IDX_IDLE_LOSS_TALLY_HIGH: rd_mux = idle_tally_reg[15:8];
         IDX_FILL_TALLY_LOW: rd_mux = fill_tally_reg[7:0];
         IDX_FILL_TALLY_HIGH: rd_mux = fill_tally_reg[15:8];
         IDX_DRAIN_TALLY_LOW: rd_mux = drain_tally_reg[7:0];
         IDX_DRAIN_TALLY_HIGH: rd_mux = drain_tally_reg[15:8];
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rd_data <= 8'h00;
         rd_valid <= 1'b0;
      end
      else
      begin
         rd_valid <= cmd_read;
         if (cmd_read)
            rd_data <= rd_mux;
      end
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cal_busy <= 1'b0;
         quiet_threshold_code <= QUIET_CODE_RESET;
      end
      else
      begin
         // The status trails the conditions by one cycle; it is meant for
         // the front end, not as a timing reference.
         cal_busy <= cal_ok;
         quiet_threshold_code <= code_reg;
      end
   end
endmodule // ccrb_register_bank
`default_nettype wire

// ===== tb/ccrb_register_bank_chk.sv
`default_nettype none
module ccrb_register_bank_chk
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic cmd_valid,
   input wire logic [7:0] host_command_byte,
   input wire logic [7:0] wr_data,
   input wire logic sense_quiet,
   input wire logic [2:0] thermal_step,
   input wire logic [7:0] rd_data,
   input wire logic rd_valid,
   input wire logic cal_busy,
   input wire logic [2:0] quiet_threshold_code
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);
   logic rd_cmd;
   assign rd_cmd = cmd_valid && !host_command_byte[7];
   property p_rd_answer;
      rd_cmd |=> rd_valid ##1 (rd_valid == $past(rd_cmd));
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("no read answer");
   property p_rd_cause;
      rd_valid |-> $past(rd_cmd);
   endproperty
   a_rd_cause: assert property (p_rd_cause) else $error("stray answer");
   property p_rd_hold;
      !rd_valid |-> $stable(rd_data);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   property p_unmapped;
      rd_cmd && host_command_byte[6:0] < 7'h73 |=> rd_data == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped not 0");
   property p_code_write;
      cmd_valid && host_command_byte == 8'hf5
      |-> ##2 quiet_threshold_code == $past(wr_data[3:1], 2);
   endproperty
   a_code_write: assert property (p_code_write) else $error("code lost");
   property p_therm;
      rd_cmd && host_command_byte[6:0] == 7'h74
      |=> rd_data == {$past(thermal_step), 5'h00};
   endproperty
   a_therm: assert property (p_therm) else $error("step read wrong");
   property p_trim_bit0;
      rd_cmd && host_command_byte[6:0] == 7'h75 |=> !rd_data[0];
   endproperty
   a_trim_bit0: assert property (p_trim_bit0) else $error("bit 0 set");
   property p_cal_quiet;
      !sense_quiet |=> !cal_busy;
   endproperty
   a_cal_quiet: assert property (p_cal_quiet) else $error("cal ran");
   property p_code_reset;
      $rose(rstn) |-> quiet_threshold_code == 3'h7;
   endproperty
   a_code_reset: assert property (p_code_reset) else $error("bad code");
   c_read: cover property (rd_valid);
   c_trim: cover property (cmd_valid && host_command_byte == 8'hf5);
   c_cal: cover property ($fell(cal_busy));
endmodule // ccrb_register_bank_chk
`default_nettype wire

// ===== tb/ccrb_host_model.sv
`default_nettype none
module ccrb_host_model
(
   input wire logic core_clk,
   output logic cmd_valid,
   output logic [7:0] host_command_byte,
   output logic [7:0] wr_data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      cmd_valid = 1'b0;
      host_command_byte = 8'h00;
      wr_data = 8'h00;
   end
   // Released fields are inverted so a stale byte is never mistaken
   // for a fresh one.
   task automatic xfer(input logic wr, input logic [6:0] idx,
                       input logic [7:0] d);
      @(posedge core_clk);
      cmd_valid <= 1'b1;
      host_command_byte <= {wr, idx};
      wr_data <= (idx == 7'h75) ? {d[7:1], 1'b0} : d;
      @(posedge core_clk);
      cmd_valid <= 1'b0;
      host_command_byte <= ~{wr, idx};
      wr_data <= ~d;
   endtask
endmodule // ccrb_host_model
`default_nettype wire

// ===== tb/tb_ccrb_register_bank.sv
`default_nettype none
module tb_ccrb_register_bank;
   timeunit 1ns;
   timeprecision 1ps;
   localparam longint HOUR = 32768;
   logic core_clk, rstn, cmd_valid, normal_mode, drain_event, fill_event;
   logic draining, filling, sense_quiet, rd_valid, cal_busy, single_wire_line;
   logic [7:0] host_command_byte, wr_data, measured_offset, rd_data, d;
   logic [2:0] thermal_step, quiet_threshold_code;
   logic [7:0] exp_q[$], msk_q[$];
   int errors = 0, n_checks = 0, cyc = 0, n, k;
   ccrb_register_bank #(.HOUR_CYCLES(HOUR)) ccrb_register_bank_i (
      .core_clk(core_clk), .rstn(rstn), .cmd_valid(cmd_valid),
      .host_command_byte(host_command_byte), .wr_data(wr_data),
      .single_wire_line(single_wire_line), .normal_mode(normal_mode),
      .drain_event(drain_event), .fill_event(fill_event),
      .draining(draining), .filling(filling), .sense_quiet(sense_quiet),
      .thermal_step(thermal_step), .measured_offset(measured_offset),
      .rd_data(rd_data), .rd_valid(rd_valid), .cal_busy(cal_busy),
      .quiet_threshold_code(quiet_threshold_code));
   ccrb_host_model ccrb_host_model_i (.core_clk(core_clk),
      .cmd_valid(cmd_valid), .host_command_byte(host_command_byte),
      .wr_data(wr_data));
   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   task automatic final_report();
      if (exp_q.size() != 0)
         errors++;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic rd(input logic [6:0] i, input logic [7:0] e,
                     input logic [7:0] m = 8'hff);
      exp_q.push_back(e);
      msk_q.push_back(m);
      ccrb_host_model_i.xfer(1'b0, i, 8'h00);
   endtask
   task automatic wr(input logic [6:0] i, input logic [7:0] v);
      ccrb_host_model_i.xfer(1'b1, i, v);
   endtask
   task automatic chk_busy(input logic e);
      @(negedge core_clk);
      n_checks++;
      if (cal_busy !== e)
      begin
         errors++;
         $display("Error at %0t: cal_busy %b", $time, cal_busy);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Answers are registered, so sampling on the falling edge is race free.
   always @(negedge core_clk)
   begin
      if (rd_valid === 1'b1)
      begin
         n_checks++;
         if (exp_q.size() == 0 || (rd_data & msk_q[0]) !== (exp_q[0] & msk_q[0]))
         begin
            errors++;
            $display("Error at %0t: read got %h", $time, rd_data);
         end
         if (exp_q.size() != 0)
         begin
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
         end
      end
   end
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 80000)
      begin
         errors++;
         final_report();
      end
   end
   initial
   begin
      void'($urandom(13));
      {rstn, normal_mode, drain_event, fill_event, draining, filling} = 0;
      sense_quiet = 1'b0;
      single_wire_line = 1'b1;
      thermal_step = 3'h3;
      measured_offset = 8'h00;
      repeat (12) @(posedge core_clk);
      rstn <= 1'b1;
      rd(7'h75, 8'h0e);
      for (k = 'h73; k <= 'h7f; k++)
         rd(7'(k), (k == 'h74) ? 8'h60 : (k == 'h75) ? 8'h0e : 8'h00);
      rd(7'h10, 8'h00);
      $display("reset test done");
      n = $urandom_range(40, 3);
      for (k = 0; k < n; k++)
      begin
         @(posedge core_clk);
         drain_event <= 1'b1;
         fill_event <= k[0];
         @(posedge core_clk);
         {drain_event, fill_event} <= 2'b00;
      end
      rd(7'h7e, 8'(n));
      rd(7'h7c, 8'(n / 2));
      wr(7'h7e, 8'h55);
      rd(7'h7e, 8'(n));
      wr(7'h74, 8'h01);
      rd(7'h7e, 8'h00);
      rd(7'h7c, 8'(n / 2));
      wr(7'h74, 8'h02);
      rd(7'h7c, 8'h00);
      d = 8'($urandom);
      wr(7'h73, d);
      rd(7'h73, d);
      for (k = 1; k < 8; k++)
      begin
         wr(7'h75, {4'h0, 3'(k), 1'b0});
         rd(7'h75, {4'h0, 3'(k), 1'b0});
         thermal_step <= 3'(k);
         rd(7'h74, {3'(k), 5'h00});
      end
      $display("register test done");
      for (k = 0; k < 2; k++)
      begin
         @(posedge core_clk);
         draining <= (k == 0);
         filling <= (k == 1);
         repeat (160) @(posedge core_clk);
         {draining, filling} <= 2'b00;
         rd(k ? 7'h76 : 7'h78, 8'h10, 8'hf8);
         rd(k ? 7'h77 : 7'h79, 8'h00);
         rd(7'h75, 8'h0e);
         wr(7'h74, k ? 8'h10 : 8'h08);
         rd(k ? 7'h76 : 7'h78, 8'h00);
      end
      rd(7'h7a, 8'h00);
      normal_mode <= 1'b1;
      repeat (2048 * 3) @(posedge core_clk);
      normal_mode <= 1'b0;
      rd(7'h7a, 8'h02, 8'hfe);
      wr(7'h74, 8'h04);
      rd(7'h7a, 8'h00);
      $display("counting test done");
      wr(7'h75, 8'h4e);
      sense_quiet <= 1'b1;
      repeat (4) @(posedge core_clk);
      chk_busy(1'b0);
      @(posedge core_clk);
      single_wire_line <= 1'b0;
      repeat (4) @(posedge core_clk);
      chk_busy(1'b1);
      @(posedge core_clk);
      single_wire_line <= 1'b1;
      repeat (4) @(posedge core_clk);
      chk_busy(1'b0);
      rd(7'h75, 8'h4e);
      sense_quiet <= 1'b0;
      wr(7'h75, 8'h0e);
      d = 8'($urandom);
      measured_offset <= d;
      wr(7'h75, 8'hce);
      sense_quiet <= 1'b1;
      repeat (20000) @(posedge core_clk);
      sense_quiet <= 1'b0;
      repeat (2) @(posedge core_clk);
      sense_quiet <= 1'b1;
      repeat (30000) @(posedge core_clk);
      chk_busy(1'b1);
      rd(7'h75, 8'hce);
      repeat (3000) @(posedge core_clk);
      rd(7'h75, 8'h0e);
      chk_busy(1'b0);
      rd(7'h73, d);
      repeat (4) @(posedge core_clk);
      $display("calibration test done");
      final_report();
   end
endmodule // tb_ccrb_register_bank
bind ccrb_register_bank ccrb_register_bank_chk chk_i (.core_clk(core_clk),
   .rstn(rstn), .cmd_valid(cmd_valid), .host_command_byte(host_command_byte),
   .wr_data(wr_data), .sense_quiet(sense_quiet), .thermal_step(thermal_step),
   .rd_data(rd_data), .rd_valid(rd_valid), .cal_busy(cal_busy),
   .quiet_threshold_code(quiet_threshold_code));
`default_nettype wire
